// ===== core/btw_basic_counter.sv
// Purpose: 8-bit basic timer counter with clear and overflow pulse
// Assumes: inc is a one-cycle tick from the basic timer divider
// Notes:   Clear wins over increment in the same cycle
`timescale 1ns/1ps
module btw_basic_counter (
    // Clock and reset
    input  wire logic                      hclk,
    input  wire logic                      hresetn,
    // Control
    input  wire logic                      inc,
    input  wire logic                      clear,
    // State
    output logic [btw_pkg::CNT_W-1:0]      count,
    output logic                           overflow
);
    typedef struct packed {
        logic [btw_pkg::CNT_W-1:0] cnt;
        logic                      ovf;
    } btw_cnt_s;

    btw_cnt_s state_reg;
    btw_cnt_s state_next;

    always_comb begin
        state_next     = state_reg;
        state_next.ovf = 1'b0;
        if (clear) begin
            state_next.cnt = '0;
        end else if (inc) begin
            state_next.cnt = state_reg.cnt + 1'b1;
            state_next.ovf = &state_reg.cnt;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign count    = state_reg.cnt;
    assign overflow = state_reg.ovf;
endmodule

// ===== core/btw_divider.sv
// Purpose: Free-running fxx divider with synchronous clear
// Assumes: fxx arrives as a one-cycle tick in the hclk domain
// Notes:   Count is the divider state; taps are decoded by the user
`timescale 1ns/1ps
module btw_divider (
    // Clock and reset
    input  wire logic                      hclk,
    input  wire logic                      hresetn,
    // Control
    input  wire logic                      fxx_tick,
    input  wire logic                      clear,
    // State
    output logic [btw_pkg::DIV_W-1:0]      count
);
    typedef struct packed {
        logic [btw_pkg::DIV_W-1:0] cnt;
    } btw_div_s;

    btw_div_s state_reg;
    btw_div_s state_next;

    always_comb begin
        state_next = state_reg;
        if (clear) begin
            state_next.cnt = '0;
        end else if (fxx_tick) begin
            state_next.cnt = state_reg.cnt + 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign count = state_reg.cnt;
endmodule

// ===== core/btw_pkg.sv
// Purpose: Shared constants for the basic timer, watchdog and clock control
// Assumes: Registers sit one per aligned 32-bit word on AHB-Lite
// Notes:   Each offset, control field position and reset value is named once here; status bit positions are not
package btw_pkg;
    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [7:0] OFS_BT_CTRL  = 8'h00;
    localparam logic [7:0] OFS_CLK_CTRL = 8'h04;
    localparam logic [7:0] OFS_STATUS   = 8'h08;

    // ************************************************************
    // Basic timer control fields
    // ************************************************************
    localparam int         BT_WDT_LSB   = 4;
    localparam int         BT_SEL_LSB   = 2;
    localparam int         BT_CNT_CLR   = 1;
    localparam int         BT_DIV_CLR   = 0;
    localparam logic [3:0] WDT_OFF_CODE = 4'hA;
    localparam logic [7:0] BT_CTRL_RST  = 8'h00;

    // ************************************************************
    // System clock control fields
    // ************************************************************
    localparam int         CK_WAKE_DIS  = 7;
    localparam int         CK_SEL_LSB   = 3;
    localparam logic [0:0] CK_WAKE_RST  = 1'h0;
    localparam logic [1:0] CK_SEL_RST   = 2'h0;

    // ************************************************************
    // Divider widths and terminal masks
    // ************************************************************
    localparam int          DIV_W        = 12;
    localparam int          CNT_W        = 8;
    localparam logic [11:0] BT_MASK_4096 = 12'hFFF;
    localparam logic [11:0] BT_MASK_1024 = 12'h3FF;
    localparam logic [11:0] BT_MASK_128  = 12'h07F;
    localparam logic [11:0] BT_MASK_16   = 12'h00F;
    localparam logic [3:0]  CK_MASK_16   = 4'hF;
    localparam logic [3:0]  CK_MASK_8    = 4'h7;
    localparam logic [3:0]  CK_MASK_2    = 4'h1;
    localparam logic [3:0]  CK_MASK_1    = 4'h0;

    // ************************************************************
    // AHB-Lite
    // ************************************************************
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ    = 2'h3;
endpackage

// ===== core/btw_top.sv
// Purpose: Basic timer, watchdog and system clock prescaler control
// Assumes: Oscillator ticks and wake request are synchronous to hclk
// Notes:   Zero-wait AHB-Lite slave, always OKAY
`timescale 1ns/1ps
module btw_top (
    // Clock and reset
    input  wire logic                  hclk,
    input  wire logic                  hresetn,
    // AHB-Lite slave
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic                  hready,
    input  wire logic [31:0]           hwdata,
    output logic [31:0]                hrdata,
    output logic                       hreadyout,
    output logic                       hresp,
    // Oscillator sources
    input  wire logic                  main_osc_tick,
    input  wire logic                  sub_osc_tick,
    input  wire logic                  sub_osc_select,
    // Power-down wake
    input  wire logic                  osc_irq,
    output logic                       main_wake,
    // Clock and timer outputs
    output logic                       sys_clk_tick,
    output logic                       bt_clk_tick,
    output logic [11:0]                tc_div_count,
    output logic [7:0]                 bt_count,
    // Watchdog
    output logic                       wdt_reset
);
    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {
        BTW_IDLE  = 2'b01,
        BTW_WDATA = 2'b10
    } btw_bus_e;

    typedef struct packed {
        btw_bus_e    bus;
        logic [7:0]  waddr;
        logic [31:0] rdata;
        logic [3:0]  wdt_code;
        logic [1:0]  bt_sel;
        logic        wake_dis;
        logic [1:0]  ck_sel;
        logic [3:0]  ck_div;
        logic        cnt_clr;
        logic        div_clr;
        logic        sys_tick;
        logic        bt_tick;
        logic        wake;
        logic        wdt_rst;
        logic [11:0] tc_cnt;
        logic [7:0]  bt_cnt;
    } btw_state_s;

    // ************************************************************
    // Signals
    // ************************************************************
    btw_state_s  state_reg;
    btw_state_s  state_next;
    logic        fxx_tick;
    logic [11:0] bt_div_count;
    logic [11:0] tc_div_raw;
    logic [7:0]  bt_cnt_raw;
    logic        bt_overflow;
    logic [11:0] bt_mask;
    logic [3:0]  ck_mask;
    logic        bt_tick_now;
    logic        addr_phase;
    logic        wdt_enabled;
    logic [7:0]  bt_ctrl_rd;
    logic [7:0]  ck_ctrl_rd;
    logic [7:0]  status_rd;

    // ************************************************************
    // Clock source
    // ************************************************************
    assign fxx_tick = sub_osc_select ? sub_osc_tick : main_osc_tick;

    // ************************************************************
    // Dividers and basic timer counter
    // ************************************************************
    btw_divider u_bt_div (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .fxx_tick (fxx_tick),
        .clear    (state_reg.div_clr),
        .count    (bt_div_count)
    );

    btw_divider u_tc_div (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .fxx_tick (fxx_tick),
        .clear    (state_reg.div_clr),
        .count    (tc_div_raw)
    );

    btw_basic_counter u_bt_cnt (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .inc      (bt_tick_now),
        .clear    (state_reg.cnt_clr),
        .count    (bt_cnt_raw),
        .overflow (bt_overflow)
    );

    // ************************************************************
    // Tap decode
    // ************************************************************
    always_comb begin
        case (state_reg.bt_sel)
            2'b00:   bt_mask = btw_pkg::BT_MASK_4096;
            2'b01:   bt_mask = btw_pkg::BT_MASK_1024;
            2'b10:   bt_mask = btw_pkg::BT_MASK_128;
            2'b11:   bt_mask = btw_pkg::BT_MASK_16;
            default: bt_mask = btw_pkg::BT_MASK_4096;
        endcase
    end

    always_comb begin
        case (state_reg.ck_sel)
            2'b00:   ck_mask = btw_pkg::CK_MASK_16;
            2'b01:   ck_mask = btw_pkg::CK_MASK_8;
            2'b10:   ck_mask = btw_pkg::CK_MASK_2;
            2'b11:   ck_mask = btw_pkg::CK_MASK_1;
            default: ck_mask = btw_pkg::CK_MASK_16;
        endcase
    end

    // Tick when all selected low divider bits are one and fxx advances
    assign bt_tick_now = fxx_tick && !state_reg.div_clr
                         && ((bt_div_count & bt_mask) == bt_mask);

    assign wdt_enabled = (state_reg.wdt_code != btw_pkg::WDT_OFF_CODE);

    // ************************************************************
    // Read data
    // ************************************************************
    // Clear strobes read back as zero
    assign bt_ctrl_rd = {state_reg.wdt_code, state_reg.bt_sel, 2'b00};
    assign ck_ctrl_rd = {state_reg.wake_dis, 2'b00, state_reg.ck_sel, 3'b000};
    assign status_rd  = {6'h00, wdt_enabled, sub_osc_select};

    assign addr_phase = hsel && hready && htrans[1];

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        state_next          = state_reg;
        state_next.cnt_clr  = 1'b0;
        state_next.div_clr  = 1'b0;
        state_next.sys_tick = 1'b0;
        state_next.wdt_rst  = 1'b0;
        state_next.bt_tick  = bt_tick_now;
        state_next.tc_cnt   = tc_div_raw;
        state_next.bt_cnt   = bt_cnt_raw;
        state_next.wake     = osc_irq && !state_reg.wake_dis;
        state_next.wdt_rst  = bt_overflow && wdt_enabled;

        // System clock prescaler
        if (state_reg.div_clr) begin
            state_next.ck_div = 4'h0;
        end else if (fxx_tick) begin
            state_next.ck_div = state_reg.ck_div + 4'h1;
            state_next.sys_tick = ((state_reg.ck_div & ck_mask) == ck_mask);
        end

        // Bus data phase
        case (state_reg.bus)
            BTW_IDLE: begin
                state_next.bus = BTW_IDLE;
            end
            BTW_WDATA: begin
                state_next.bus = BTW_IDLE;
                case (state_reg.waddr)
                    btw_pkg::OFS_BT_CTRL: begin
                        state_next.wdt_code = hwdata[btw_pkg::BT_WDT_LSB +: 4];
                        state_next.bt_sel   = hwdata[btw_pkg::BT_SEL_LSB +: 2];
                        state_next.cnt_clr  = hwdata[btw_pkg::BT_CNT_CLR];
                        state_next.div_clr  = hwdata[btw_pkg::BT_DIV_CLR];
                    end
                    btw_pkg::OFS_CLK_CTRL: begin
                        state_next.wake_dis = hwdata[btw_pkg::CK_WAKE_DIS];
                        state_next.ck_sel   = hwdata[btw_pkg::CK_SEL_LSB +: 2];
                    end
                    default: begin
                        state_next.wake_dis = state_reg.wake_dis;
                    end
                endcase
            end
            default: begin
                state_next.bus = BTW_IDLE;
            end
        endcase

        // Address phase
        if (addr_phase) begin
            state_next.waddr = haddr[7:0];
            if (hwrite) begin
                state_next.bus   = BTW_WDATA;
                state_next.rdata = 32'h00000000;
            end else begin
                case (haddr[7:0])
                    btw_pkg::OFS_BT_CTRL:  state_next.rdata = {24'h000000, bt_ctrl_rd};
                    btw_pkg::OFS_CLK_CTRL: state_next.rdata = {24'h000000, ck_ctrl_rd};
                    btw_pkg::OFS_STATUS:   state_next.rdata = {24'h000000, status_rd};
                    default:               state_next.rdata = 32'h00000000;
                endcase
            end
        end
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg          <= '0;
            state_reg.bus      <= BTW_IDLE;
            state_reg.wdt_code <= btw_pkg::BT_CTRL_RST[7:4];
            state_reg.bt_sel   <= btw_pkg::BT_CTRL_RST[3:2];
            state_reg.wake_dis <= btw_pkg::CK_WAKE_RST[0];
            state_reg.ck_sel   <= btw_pkg::CK_SEL_RST;
        end else begin
            state_reg <= state_next;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign hrdata       = state_reg.rdata;
    assign hreadyout    = 1'b1;
    assign hresp        = 1'b0;
    assign main_wake    = state_reg.wake;
    assign sys_clk_tick = state_reg.sys_tick;
    assign bt_clk_tick  = state_reg.bt_tick;
    assign tc_div_count = state_reg.tc_cnt;
    assign bt_count     = state_reg.bt_cnt;
    assign wdt_reset    = state_reg.wdt_rst;
endmodule

// ===== tb/btw_top_bench.sv
// Purpose: Self-checking bench for timer, watchdog and clock control
// Assumes: Selected oscillator ticks every cycle, the other at random
// Notes:   Tick periods are measured between output pulses
`timescale 1ns/1ps
module btw_top_bench;
    logic        hclk, hresetn, hsel, hwrite, sub_osc_select, osc_irq, main_osc_tick, sub_osc_tick;
    logic        hreadyout, hresp, main_wake, sys_clk_tick, bt_clk_tick, wdt_reset;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [11:0] tc_div_count;
    logic [7:0]  bt_count;
    wire logic   hready = hreadyout;
    int          num_errors = 0;
    int          n_tests = 0;
    int          n;
    btw_top i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready, .hwdata, .hrdata,
        .hreadyout, .hresp, .main_osc_tick, .sub_osc_tick, .sub_osc_select, .osc_irq, .main_wake,
        .sys_clk_tick, .bt_clk_tick, .tc_div_count, .bt_count, .wdt_reset);
    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        main_osc_tick <= sub_osc_select ? 1'($urandom) : 1'b1;
        sub_osc_tick  <= sub_osc_select ? 1'b1 : 1'($urandom);
    end
    function automatic int bt_div(input logic [1:0] c);
        return c == 2'h0 ? 4096 : c == 2'h1 ? 1024 : c == 2'h2 ? 128 : 16;
    endfunction
    function automatic int sys_div(input logic [1:0] c);
        return c == 2'h0 ? 16 : c == 2'h1 ? 8 : c == 2'h2 ? 2 : 1;
    endfunction
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL %0t %s", $time, msg);
        end
    endtask
    task automatic wait_rdy;
        int k;
        k = 0;
        do begin
            @(posedge hclk);
            k++;
        end while (hready !== 1'b1 && k < 20);
        if (k >= 20) begin
            num_errors++;
            conclude();
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        hwrite <= w;
        htrans <= btw_pkg::HTRANS_NONSEQ;
        wait_rdy();
        htrans <= 2'h0;
        hsel   <= 1'b0;
        hwdata <= {24'h0, d};
        wait_rdy();
        rd = hrdata;
    endtask
    task automatic gap(input logic sys);
        n = 0;
        do begin
            @(negedge hclk);
            n++;
        end while ((sys ? sys_clk_tick : bt_clk_tick) !== 1'b1 && n < 9000);
        if (n >= 9000) begin
            num_errors++;
            conclude();
        end
    endtask
    task automatic period(input logic sys, input int exp);
        repeat (4) @(posedge hclk);
        gap(sys);
        gap(sys);
        check(32'(n), 32'(exp), "tick period");
        @(posedge hclk);
    endtask
    task automatic count_wdt(input int exp);
        int m;
        m = 0;
        repeat (4200) begin
            @(negedge hclk);
            if (wdt_reset === 1'b1) m++;
        end
        check(32'(m), 32'(exp), "watchdog pulses");
        @(posedge hclk);
    endtask
    initial begin
        logic [7:0] d;
        {hresetn, hsel, hwrite, sub_osc_select, osc_irq, main_osc_tick, sub_osc_tick} = 7'h00;
        {haddr, hwdata, htrans} = 66'h0;
        hsize = 3'h2;
        void'($urandom(31335));
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        bus(1'b0, btw_pkg::OFS_BT_CTRL, 8'h00);
        check(rd, 32'h0, "timer control reset");
        bus(1'b0, btw_pkg::OFS_CLK_CTRL, 8'h00);
        check(rd, 32'h0, "clock control reset");
        period(1'b1, 16);
        bus(1'b0, 8'h0C, 8'h00);
        check(rd, 32'h0, "unmapped read");
        $display("test reset done");
        for (int c = 0; c < 4; c++) begin
            sub_osc_select <= 1'($urandom);
            bus(1'b1, btw_pkg::OFS_CLK_CTRL, {3'h0, 2'(c), 3'h0});
            bus(1'b1, btw_pkg::OFS_BT_CTRL, {4'hA, 2'(c), 2'h1});
            period(1'b0, bt_div(2'(c)));
            period(1'b1, sys_div(2'(c)));
        end
        $display("test dividers done");
        repeat (6) begin
            d = 8'($urandom);
            bus(1'b1, btw_pkg::OFS_BT_CTRL, d);
            bus(1'b0, btw_pkg::OFS_BT_CTRL, 8'h00);
            check(rd, {24'h0, d[7:2], 2'h0}, "timer control readback");
            bus(1'b1, btw_pkg::OFS_CLK_CTRL, d);
            bus(1'b0, btw_pkg::OFS_CLK_CTRL, 8'h00);
            check(rd, {24'h0, d & 8'h98}, "clock control readback");
        end
        $display("test readback done");
        for (int b = 0; b < 2; b++) begin
            bus(1'b1, btw_pkg::OFS_CLK_CTRL, {1'(b), 7'h00});
            osc_irq <= 1'b1;
            repeat (3) @(posedge hclk);
            @(negedge hclk);
            check({31'h0, main_wake}, {31'h0, ~1'(b)}, "wake gate");
            @(posedge hclk);
            osc_irq <= 1'b0;
        end
        $display("test wake done");
        sub_osc_select <= 1'b0;
        bus(1'b1, btw_pkg::OFS_BT_CTRL, {4'h5, 2'h3, 2'h3});
        repeat (4) @(posedge hclk);
        @(negedge hclk);
        check({24'h0, bt_count}, 32'h0, "count after clear");
        @(posedge hclk);
        count_wdt(1);
        bus(1'b1, btw_pkg::OFS_BT_CTRL, {4'hA, 2'h3, 2'h3});
        count_wdt(0);
        $display("test watchdog done");
        conclude();
    end
endmodule

// ===== tb/btw_top_monitor.sv
// Purpose: Port assertions for timer, watchdog and clock control
// Assumes: Shadow bits follow bus writes at the data-phase edge
// Notes:   Bound to btw_top
`timescale 1ns/1ps
module btw_top_monitor (
    // Clock and reset
    input wire logic        hclk,
    input wire logic        hresetn,
    // Bus
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    // Block
    input wire logic        main_osc_tick,
    input wire logic        sub_osc_tick,
    input wire logic        sub_osc_select,
    input wire logic        osc_irq,
    input wire logic        main_wake,
    input wire logic        sys_clk_tick,
    input wire logic        bt_clk_tick,
    input wire logic [11:0] tc_div_count,
    input wire logic [7:0]  bt_count,
    input wire logic        wdt_reset
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic       wr_bt;
    logic       wr_ck;
    logic       wk_dis;
    logic [3:0] code;
    wire logic  ap  = hsel && hready && htrans[1];
    wire logic  fxx = sub_osc_select ? sub_osc_tick : main_osc_tick;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_bt  <= 1'b0;
            wr_ck  <= 1'b0;
            code   <= 4'h0;
            wk_dis <= 1'b0;
        end else begin
            wr_bt <= ap && hwrite && haddr[7:0] == btw_pkg::OFS_BT_CTRL;
            wr_ck <= ap && hwrite && haddr[7:0] == btw_pkg::OFS_CLK_CTRL;
            code  <= wr_bt ? hwdata[7:4] : code;
            wk_dis <= wr_ck ? hwdata[7] : wk_dis;
        end
    end
    sequence s_bt_wr;
        wr_bt;
    endsequence
    sequence s_rd(logic [7:0] a);
        ap && !hwrite && haddr[7:0] == a;
    endsequence
    chk_ready_okay: assert property (hreadyout && !hresp)
        else $error("bus not ready or not okay");
    chk_cnt_clear: assert property (s_bt_wr ##0 hwdata[1] |-> ##[2:3] bt_count == 8'h00)
        else $error("basic count not cleared");
    chk_div_clear: assert property (s_bt_wr ##0 hwdata[0] |-> ##[2:3] tc_div_count == 12'h000)
        else $error("divider not cleared");
    chk_strobe_read: assert property (s_rd(btw_pkg::OFS_BT_CTRL) |-> ##1 hrdata[1:0] == 2'h0)
        else $error("clear bits read back set");
    chk_unmapped_read: assert property (s_rd(8'h0C) |-> ##1 hrdata == 32'h0)
        else $error("unmapped read not zero");
    chk_wake_gate: assert property ($past(wk_dis) == wk_dis |-> main_wake == ($past(osc_irq) && !wk_dis))
        else $error("wake output wrong");
    chk_wdt_off: assert property ($past(code, 2) == code && code == btw_pkg::WDT_OFF_CODE |-> !wdt_reset)
        else $error("watchdog fired while disabled");
    chk_wdt_cause: assert property (wdt_reset |-> $past(bt_count) == 8'hFF || $past(bt_count, 2) == 8'hFF)
        else $error("watchdog fired without overflow");
    chk_fxx_source: assert property (bt_clk_tick || sys_clk_tick |-> $past(fxx) || $past(fxx, 2))
        else $error("tick without source tick");
endmodule
bind btw_top btw_top_monitor i_mon (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hwdata, .hrdata,
    .hreadyout, .hresp, .main_osc_tick, .sub_osc_tick, .sub_osc_select, .osc_irq, .main_wake, .sys_clk_tick,
    .bt_clk_tick, .tc_div_count, .bt_count, .wdt_reset);
